// *** include/strap_pkg.sv ***
`default_nettype none
package strap_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses on the APB)
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_STRAP_STATUS = 12'h000;
   localparam logic [11:0] ADDR_OVERRIDE = 12'h004;
   localparam logic [11:0] ADDR_SETTINGS = 12'h008;

   // ------------------------------------------------------------
   // Strap bit positions in the status word
   // ------------------------------------------------------------
   localparam int STRAP_COUNT = 5;
   localparam int BIT_LDO = 0;
   localparam int BIT_BOOT_A = 1;
   localparam int BIT_BOOT_B = 2;
   localparam int BIT_LOG_EDGE = 3;
   localparam int BIT_OUT_EDGE = 4;

   // Pull level applied to each strap pin during reset
   localparam logic [4:0] PULL_LEVELS = 5'h1a;
   // Value of the latch before the first capture
   localparam logic [4:0] STRAP_RESET = 5'h00;

   // ------------------------------------------------------------
   // Override register fields
   // ------------------------------------------------------------
   localparam int OVR_LDO_EN = 0;
   localparam int OVR_LDO_VAL = 1;
   localparam int OVR_EDGE_EN = 2;
   localparam int OVR_EDGE_LO = 3;
   localparam int OVR_EDGE_HI = 4;
   localparam logic [4:0] OVERRIDE_RESET = 5'h00;

   // ------------------------------------------------------------
   // Settings readback fields
   // ------------------------------------------------------------
   localparam int SET_LDO_18 = 0;
   localparam int SET_FLASH_BOOT = 1;
   localparam int SET_LOG_ON = 2;
   localparam int SET_EDGE_LO = 3;
   localparam int SET_EDGE_HI = 4;
   localparam int SET_CAPTURED = 5;

   // Capture sequencer states, Gray along the usual path
   typedef enum logic [1:0]
   {
      ST_RESET = 2'b00,
      ST_CAPTURE = 2'b01,
      ST_LOCKED = 2'b11
   } capture_state_e;
endpackage : strap_pkg
`default_nettype wire

// *** core/strap_bit.sv ***
`timescale 1ns/10ps
`default_nettype none
module strap_bit
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Control
   input wire logic capture,
   input wire logic pull_level,
   input wire logic pin_oe,
   input wire logic pin_level,
   // Result
   output logic value
);
   // Pin seen at capture: pull wins when nobody drives the pin
   logic level;

   always_comb
   begin
      level = pin_oe ? pin_level : pull_level;
   end

   // Latch that only the capture pulse can load
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         value <= 1'b0;
      end
      else if (ce && capture)
      begin
         value <= level;
      end
   end
endmodule : strap_bit
`default_nettype wire

// *** core/strap_pin_latch.sv ***
// How it works
// RULE1: Sample five strap pins at reset release
// RULE2: Latches hold until power down
// RULE3: Software reads latched bits via status register
// RULE4: Weak pulls on strap pins during reset
// RULE5: Pins return to normal use after release
// RULE6: LDO strap 0 gives 3.3V, 1 gives 1.8V
// RULE7: Boot A high flash boot, both low download
// RULE8: Log strap high enables boot log output
// RULE9: Two straps pick SDIO sample/output edges
// RULE10: Firmware may override LDO and edge settings
// RULE11: Host must not strap LDO high
// RULE12: Host may drive straps during power-up
// RULE13: Enable input active high, low holds all
// RULE14: Flash pins are not reused
// RULE15: Status returns latched, not live, levels
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module strap_pin_latch
(
   // Clock, reset and enable
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic MODULE_EN,
   // Strap pins: level seen and whether the outside drives them
   input wire logic [4:0] STRAP_PIN_IN,
   input wire logic [4:0] STRAP_PIN_DRIVEN,
   // Pull control towards the pad cells
   output logic [4:0] STRAP_PULL_UP_EN,
   output logic [4:0] STRAP_PULL_DOWN_EN,
   output logic STRAP_PINS_NORMAL,
   // Decoded settings
   output logic LDO_SDIO_1V8,
   output logic FLASH_BOOT,
   output logic DOWNLOAD_BOOT,
   output logic BOOT_LOG_ENABLE,
   output logic SDIO_SAMPLE_RISING,
   output logic SDIO_OUTPUT_RISING,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   strap_pkg::capture_state_e state; // Capture sequencer
   strap_pkg::capture_state_e next_state;
   logic capture; // One-cycle capture strobe
   logic [4:0] strap; // Latched strap bits
   logic [4:0] override; // Firmware override register
   logic captured; // Capture has happened
   logic ldo_1v8; // Effective LDO choice
   logic edge_lo; // Effective edge code, low bit
   logic edge_hi; // Effective edge code, high bit
   logic flash_boot; // Boot from flash
   logic download_boot; // Wait for a download
   logic apb_access; // Access phase of any transfer
   logic addr_ok; // Address decodes to a register
   logic override_write; // Override write, taken with ready
   logic [31:0] next_prdata; // Read word for the addressed register

   // ------------------------------------------------------------
   // Capture sequencer
   // ------------------------------------------------------------
   // Reset holds the sequencer; the second enabled cycle after
   // release captures once and then the latch is closed for good.
   // A single strobe, rather than a level, keeps a pin that moves
   // late from leaking into the latches after the capture.
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         state <= strap_pkg::ST_RESET;
      end
      else if (MODULE_EN) // RULE13
      begin
         state <= next_state;
      end
   end

   always_comb
   begin
      next_state = state;
      unique case (state)
         strap_pkg::ST_RESET:
         begin
            next_state = strap_pkg::ST_CAPTURE; // RULE1
         end
         strap_pkg::ST_CAPTURE:
         begin
            next_state = strap_pkg::ST_LOCKED;
         end
         strap_pkg::ST_LOCKED:
         begin
            next_state = strap_pkg::ST_LOCKED; // RULE2
         end
         default:
         begin
            // Illegal code: lock rather than re-sample
            next_state = strap_pkg::ST_LOCKED;
         end
      endcase
   end

   // Strobe only in the capture state, so later pin moves are ignored
   assign capture = (state == strap_pkg::ST_CAPTURE); // RULE1 RULE2

   // ------------------------------------------------------------
   // Strap latches
   // ------------------------------------------------------------
   // One cell per pin; pull level stands in for an undriven pin
   // The same small cell for every pin keeps the five from drifting apart
   genvar g;
   generate
      for (g = 0; g < strap_pkg::STRAP_COUNT; g++)
      begin : g_strap
         strap_bit u_bit
         (
            .clk(CORE_CLK),
            .rst(SYS_RST),
            .ce(MODULE_EN),
            .capture(capture),
            .pull_level(strap_pkg::PULL_LEVELS[g]), // RULE4
            .pin_oe(STRAP_PIN_DRIVEN[g]), // RULE12
            .pin_level(STRAP_PIN_IN[g]),
            .value(strap[g])
         );
      end
   endgenerate

   // Captured flag for software
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         captured <= 1'b0;
      end
      else if (MODULE_EN && capture)
      begin
         captured <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Pad control
   // ------------------------------------------------------------
   // Pulls stay on until the latch closes; they are weak, so a host
   // driving a pin during reset still wins over them
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         // Each pin pulled towards its default strap level
         STRAP_PULL_UP_EN <= strap_pkg::PULL_LEVELS; // RULE4
         STRAP_PULL_DOWN_EN <= ~strap_pkg::PULL_LEVELS;
      end
      else if (MODULE_EN && capture)
      begin
         // Pulls released at the same edge as the latches load
         STRAP_PULL_UP_EN <= 5'h00; // RULE5
         STRAP_PULL_DOWN_EN <= 5'h00;
      end
   end

   // Pins handed back to their normal functions after the capture
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         STRAP_PINS_NORMAL <= 1'b0;
      end
      else if (MODULE_EN && capture)
      begin
         STRAP_PINS_NORMAL <= 1'b1; // RULE5
      end
   end

   // ------------------------------------------------------------
   // Override register write
   // ------------------------------------------------------------
   assign apb_access = PSEL && PENABLE;
   assign addr_ok = (PADDR == strap_pkg::ADDR_STRAP_STATUS) ||
                    (PADDR == strap_pkg::ADDR_OVERRIDE) ||
                    (PADDR == strap_pkg::ADDR_SETTINGS);

   // A write lands only at the edge that completes the transfer, so
   // the wait state never applies a half-finished request
   assign override_write = apb_access && PWRITE && PREADY &&
                           (PADDR == strap_pkg::ADDR_OVERRIDE);

   // Firmware override of LDO and SDIO edges after boot
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         override <= strap_pkg::OVERRIDE_RESET;
      end
      else if (MODULE_EN && override_write)
      begin
         // Writes elsewhere, read-only words included, change nothing
         override <= PWDATA[4:0]; // RULE10
      end
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   // Note: the LDO strap must be low at power-up for 3.3V flash;
   // nothing here stops a bad strap, the board has to.
   always_comb
   begin
      // Override enables pick the firmware value, else the latch
      // RULE6 RULE10 RULE11
      ldo_1v8 = override[strap_pkg::OVR_LDO_EN] ? override[strap_pkg::OVR_LDO_VAL]
                                                : strap[strap_pkg::BIT_LDO];
      // RULE9 RULE10
      edge_hi = override[strap_pkg::OVR_EDGE_EN] ? override[strap_pkg::OVR_EDGE_HI]
                                                 : strap[strap_pkg::BIT_LOG_EDGE];
      edge_lo = override[strap_pkg::OVR_EDGE_EN] ? override[strap_pkg::OVR_EDGE_LO]
                                                 : strap[strap_pkg::BIT_OUT_EDGE];
      // RULE7: second strap only matters when the first is low
      flash_boot = strap[strap_pkg::BIT_BOOT_A];
      download_boot = ~strap[strap_pkg::BIT_BOOT_A] & ~strap[strap_pkg::BIT_BOOT_B];
   end

   // Boot outputs, low until the first capture; they come from the
   // latches alone, so firmware cannot change them after booting
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         FLASH_BOOT <= 1'b0;
         DOWNLOAD_BOOT <= 1'b0;
         BOOT_LOG_ENABLE <= 1'b0;
      end
      else if (MODULE_EN && captured)
      begin
         FLASH_BOOT <= flash_boot; // RULE7
         DOWNLOAD_BOOT <= download_boot; // RULE7
         BOOT_LOG_ENABLE <= strap[strap_pkg::BIT_LOG_EDGE]; // RULE8
      end
   end

   // Supply and SDIO edge outputs follow the decode every cycle after the capture, so
   // an override acts one cycle after it is written
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         LDO_SDIO_1V8 <= 1'b0;
         SDIO_SAMPLE_RISING <= 1'b0;
         SDIO_OUTPUT_RISING <= 1'b0;
      end
      else if (MODULE_EN && captured)
      begin
         LDO_SDIO_1V8 <= ldo_1v8; // RULE6
         SDIO_SAMPLE_RISING <= edge_hi; // RULE9
         SDIO_OUTPUT_RISING <= edge_lo; // RULE9
      end
   end

   // ------------------------------------------------------------
   // APB read and answer
   // ------------------------------------------------------------
   always_comb
   begin
      next_prdata = 32'h0000_0000;
      unique case (PADDR)
         strap_pkg::ADDR_STRAP_STATUS:
         begin
            // Latched bits only, never the live pins
            next_prdata[4:0] = strap; // RULE3 RULE15
         end
         strap_pkg::ADDR_OVERRIDE:
         begin
            // Reads back as written
            next_prdata[4:0] = override;
         end
         strap_pkg::ADDR_SETTINGS:
         begin
            // Effective settings, overrides applied
            next_prdata[strap_pkg::SET_LDO_18] = ldo_1v8;
            next_prdata[strap_pkg::SET_FLASH_BOOT] = flash_boot;
            next_prdata[strap_pkg::SET_LOG_ON] = strap[strap_pkg::BIT_LOG_EDGE];
            next_prdata[strap_pkg::SET_EDGE_LO] = edge_lo;
            next_prdata[strap_pkg::SET_EDGE_HI] = edge_hi;
            next_prdata[strap_pkg::SET_CAPTURED] = captured;
         end
         default:
         begin
            // Unmapped reads return zero with an error
            next_prdata = 32'h0000_0000;
         end
      endcase
   end

   // ------------------------------------------------------------
   // APB answer
   // ------------------------------------------------------------
   // Ready rises in the second access cycle, so every transfer
   // has one wait state; in return all bus outputs come from flops.
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         PREADY <= 1'b0;
      end
      else if (MODULE_EN)
      begin
         // Ready stands one cycle; a held request is not answered in two cycles running
         PREADY <= PSEL && PENABLE && !PREADY;
      end
   end

   // Error flag goes up with ready, only for an address off the map
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         PSLVERR <= 1'b0;
      end
      else if (MODULE_EN)
      begin
         PSLVERR <= PSEL && PENABLE && !PREADY && !addr_ok;
      end
   end

   // Read data follows the address while the transfer waits, then
   // stands unchanged through the cycle in which ready is high
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         PRDATA <= 32'h0000_0000;
      end
      else if (MODULE_EN && PSEL && !PREADY)
      begin
         PRDATA <= next_prdata;
      end
   end
endmodule : strap_pin_latch
`default_nettype wire

// *** bench/strap_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
// Port-level watch on the strap latch; reset masks every property
module strap_checker
(
   // Clock, reset and enable
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic MODULE_EN,
   // Pad control and settings
   input wire logic [4:0] STRAP_PULL_UP_EN,
   input wire logic [4:0] STRAP_PULL_DOWN_EN,
   input wire logic STRAP_PINS_NORMAL,
   input wire logic LDO_SDIO_1V8,
   input wire logic FLASH_BOOT,
   input wire logic DOWNLOAD_BOOT,
   // APB
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   pulls_before_capture_a: assert property (!STRAP_PINS_NORMAL |->
      STRAP_PULL_UP_EN == 5'h1a && STRAP_PULL_DOWN_EN == 5'h05) else $error("pulls wrong");
   pulls_released_a: assert property (STRAP_PINS_NORMAL |->
      (STRAP_PULL_UP_EN | STRAP_PULL_DOWN_EN) == 5'h00) else $error("pulls left on");
   pins_stay_normal_a: assert property (STRAP_PINS_NORMAL |=> STRAP_PINS_NORMAL)
      else $error("normal mode lost");
   boot_exclusive_a: assert property (FLASH_BOOT |-> !DOWNLOAD_BOOT)
      else $error("two boot modes");
   apb_answer_a: assert property (PSEL && !PENABLE && MODULE_EN |=> !PREADY ##1 PREADY)
      else $error("apb answer late");
   ready_one_cycle_a: assert property (PREADY |=> !PREADY) else $error("ready held");
   unmapped_error_a: assert property (PREADY && PADDR > 12'h008 |->
      PSLVERR && PRDATA == 32'h0) else $error("unmapped not refused");
   status_width_a: assert property (PREADY && !PWRITE && PADDR == 12'h000 |->
      PRDATA[31:5] == 27'h0) else $error("status upper bits set");
   enable_freeze_a: assert property (!MODULE_EN |=>
      $stable(STRAP_PINS_NORMAL) && $stable(LDO_SDIO_1V8)) else $error("moved while off");
   cover property (PREADY && PSLVERR);
   cover property ($rose(STRAP_PINS_NORMAL));
   cover property (!MODULE_EN && !STRAP_PINS_NORMAL);
endmodule : strap_checker
bind strap_pin_latch strap_checker chk (.CORE_CLK, .SYS_RST, .MODULE_EN, .STRAP_PULL_UP_EN,
   .STRAP_PULL_DOWN_EN, .STRAP_PINS_NORMAL, .LDO_SDIO_1V8, .FLASH_BOOT, .DOWNLOAD_BOOT,
   .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR);
`default_nettype wire

// *** bench/strap_partner.sv ***
`timescale 1ns/10ps
`default_nettype none
// Board side of the straps: host GPIOs, else pad pulls, else a floating pin
module strap_partner
(
   // Clock
   input wire logic clk,
   // From the pad cells and the host
   input wire logic [4:0] pull_up_en,
   input wire logic [4:0] pull_down_en,
   input wire logic [4:0] host_drive,
   input wire logic [4:0] host_level,
   // Towards the pins
   // Only the five strap pins are modelled; flash pins stay untouched
   output logic [4:0] pin_in,
   output logic [4:0] pin_driven
);
   logic [4:0] last; // Previous pin level
   // Floating pins toggle so a stale value can never pass as a latch
   always_ff @(posedge clk) last <= pin_in;
   // Host never straps the supply bit high, the flash needs 3.3 V
   always_comb
   begin
      for (int i = 0; i < 5; i++)
         pin_in[i] = host_drive[i] ? (host_level[i] && i != 0) :
            pull_up_en[i] ? 1'b1 : pull_down_en[i] ? 1'b0 : ~last[i];
   end
   assign pin_driven = host_drive;
endmodule : strap_partner
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic CORE_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic MODULE_EN = 1'b1;
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic [4:0] STRAP_PIN_IN, STRAP_PIN_DRIVEN, STRAP_PULL_UP_EN, STRAP_PULL_DOWN_EN;
   logic [4:0] drv = 5'h00, lvl = 5'h00;
   logic STRAP_PINS_NORMAL, LDO_SDIO_1V8, FLASH_BOOT, DOWNLOAD_BOOT, BOOT_LOG_ENABLE;
   logic SDIO_SAMPLE_RISING, SDIO_OUTPUT_RISING, PREADY, PSLVERR, err;
   int mismatches = 0, checked = 0, cycles = 0;
   strap_pin_latch DUT (.CORE_CLK, .SYS_RST, .MODULE_EN, .STRAP_PIN_IN, .STRAP_PIN_DRIVEN,
      .STRAP_PULL_UP_EN, .STRAP_PULL_DOWN_EN, .STRAP_PINS_NORMAL, .LDO_SDIO_1V8, .FLASH_BOOT,
      .DOWNLOAD_BOOT, .BOOT_LOG_ENABLE, .SDIO_SAMPLE_RISING, .SDIO_OUTPUT_RISING, .PSEL,
      .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR);
   strap_partner board (.clk(CORE_CLK), .pull_up_en(STRAP_PULL_UP_EN),
      .pull_down_en(STRAP_PULL_DOWN_EN), .host_drive(drv), .host_level(lvl),
      .pin_in(STRAP_PIN_IN), .pin_driven(STRAP_PIN_DRIVEN));
   initial forever #25 CORE_CLK = ~CORE_CLK;
   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge CORE_CLK)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         complete_run();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One APB transfer; request held until PREADY is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n = 0;
      @(posedge CORE_CLK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      do
      begin
         @(posedge CORE_CLK);
         n++;
      end
      while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      chk("access_cycles", 32'd2, n);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   // Reset with the host holding the straps, then drive high the pins strapped low and release the rest
   task automatic restart(input logic [4:0] d, input logic [4:0] l);
      SYS_RST <= 1'b1;
      drv <= d;
      lvl <= l;
      repeat (10) @(posedge CORE_CLK);
      chk("pull_up", 32'h1a, STRAP_PULL_UP_EN);
      chk("pull_down", 32'h05, STRAP_PULL_DOWN_EN);
      SYS_RST <= 1'b0;
      repeat (4) @(posedge CORE_CLK);
      drv <= ~l;
      lvl <= ~l;
   endtask : restart
   task automatic check_straps(input logic [4:0] s);
      apb(1'b0, 12'h000, 32'h0);
      chk("status", {27'h0, s}, rd);
      chk("slverr", 32'h0, err);
      chk("ldo", s[0], LDO_SDIO_1V8);
      chk("flash", s[1], FLASH_BOOT);
      chk("download", !s[1] && !s[2], DOWNLOAD_BOOT);
      chk("log", s[3], BOOT_LOG_ENABLE);
      chk("edges", {s[3], s[4]}, {SDIO_SAMPLE_RISING, SDIO_OUTPUT_RISING});
      chk("pulls", 32'h0, {STRAP_PULL_UP_EN, STRAP_PULL_DOWN_EN});
      chk("normal", 32'h1, STRAP_PINS_NORMAL);
   endtask : check_straps
   // Every boot, log and edge code; the last run leaves the pins to the pulls
   task automatic test_capture();
      for (int p = 0; p < 16; p++)
      begin
         restart(5'h1f, {p[3:0], 1'b0});
         check_straps({p[3:0], 1'b0});
      end
      restart(5'h00, 5'h00);
      check_straps(5'h1a);
      $display("capture test finished");
   endtask : test_capture
   // Firmware overrides on top of strap 1a; read-only and unmapped places
   task automatic test_override();
      logic [4:0] ov [3] = '{5'h1f, 5'h0d, 5'h0b};
      logic [1:0] code;
      logic ldo;
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, 12'h004, {27'h0, ov[i]});
         repeat (2) @(posedge CORE_CLK);
         ldo = ov[i][0] ? ov[i][1] : 1'b0;
         code = ov[i][2] ? ov[i][4:3] : 2'b11;
         chk("ldo_ovr", ldo, LDO_SDIO_1V8);
         chk("edge_ovr", code, {SDIO_SAMPLE_RISING, SDIO_OUTPUT_RISING});
         apb(1'b0, 12'h004, 32'h0);
         chk("override", {27'h0, ov[i]}, rd);
         apb(1'b0, 12'h008, 32'h0);
         chk("settings", {26'h0, 1'b1, code[1], code[0], 2'b11, ldo}, rd);
      end
      apb(1'b1, 12'h000, 32'hffffffff);
      apb(1'b0, 12'h000, 32'h0);
      chk("status_ro", 32'h1a, rd);
      apb(1'b0, 12'h00c, 32'h0);
      chk("unmapped_err", 32'h1, err);
      chk("unmapped", 32'h0, rd);
      $display("override test finished");
   endtask : test_override
   // With the enable low nothing is captured, even after reset release
   task automatic test_enable();
      MODULE_EN <= 1'b0;
      restart(5'h00, 5'h00);
      repeat (4) @(posedge CORE_CLK);
      chk("frozen", 32'h0, STRAP_PINS_NORMAL);
      MODULE_EN <= 1'b1;
      repeat (4) @(posedge CORE_CLK);
      // The host drives 1f by now; the supply bit is never driven high
      check_straps(5'h1e);
      $display("enable test finished");
   endtask : test_enable
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   initial
   begin
      test_capture();
      test_override();
      test_enable();
      complete_run();
   end
endmodule : testbench
`default_nettype wire
